// File: hdl/lvrr_top.sv
/*
 holds the low-voltage and runaway reset supervisor top.
 assumes clk_sys is the oscillation clock, reset_n is power-on reset, and the
 cpu drives the clear and mode levels synchronously to clk_sys.
// Function
// (RULE1) 20-bit counter overflow requests internal reset
// (RULE2) counter runs by itself after power-on reset
// (RULE3) software clears counter before every overflow
// (RULE4) runaway reset lasts exactly five machine cycles
// (RULE5) standby recovery extends period by 20 us
// (RULE6) low voltage sets flag, asserts reset
// (RULE7) detection works and ends stop mode
// (RULE8) low-voltage reset waits for ram write
// (RULE9) low-voltage request ignored during reset output
// (RULE10) clear strobe or internal reset zeroes counter
*/
`timescale 1ns/100ps
`include "lvrr_regs.svh"

module lvrr_top
	import lvrr_pkg::*;
#(
	parameter int RUNAWAY_BITS = `LVRR_RUNAWAY_BITS
)
(
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic low_voltage_async,
	input wire logic ram_write_busy,
	input wire logic runaway_clear,
	input wire logic standby_recover,
	input wire logic stop_mode,
	input wire logic flag_clear,
	output logic internal_reset,
	output logic stop_release,
	output lvrr_status_t status
);

	localparam int EXT_LAST = `LVRR_EXT_CYCLES - 1;
	localparam int RR_CYC = `LVRR_RUNAWAY_RST_CYCLES;

	// comparator level after two flops
	logic lv_sync;
	// runaway counter
	logic [RUNAWAY_BITS-1:0] cnt_q;
	logic [RUNAWAY_BITS-1:0] cnt_d;
	// extension counter
	logic [`LVRR_EXT_BITS-1:0] ext_q;
	logic [`LVRR_EXT_BITS-1:0] ext_d;
	// reset pulse counter
	logic [`LVRR_PULSE_BITS-1:0] pulse_q;
	logic [`LVRR_PULSE_BITS-1:0] pulse_d;
	// supervisor state
	lvrr_state_t state_q;
	lvrr_state_t state_d;
	// pending low-voltage request
	logic lv_pend_q;
	logic lv_pend_d;
	// sticky low-voltage flag
	logic flag_q;
	logic flag_d;
	// stop release pulse
	logic stop_rel_q;
	logic stop_rel_d;
	// registered copy of the outputs, so the reset line never glitches on a state change
	lvrr_status_t status_q;
	lvrr_status_t status_d;
	// decoded events
	logic resetting;
	logic carry;
	logic runaway_fire;
	logic lv_fire;

	// bring the comparator output into clk_sys
	lvrr_sync #(
		.WIDTH(1)
	) u_sync (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.async_in(low_voltage_async),
		.sync_out(lv_sync)
	);

	// event decode
	always_comb
	begin
		resetting = (state_q == LVRR_ST_RUNAWAY_RST) || (state_q == LVRR_ST_LV_RST);
		carry = &cnt_q; // RULE1
		// overflow in idle without standby, or end of extension
		runaway_fire = 1'b0;
		if (!runaway_clear)
		begin
			if (state_q == LVRR_ST_IDLE)
				runaway_fire = carry && !standby_recover; // RULE1
			else if (state_q == LVRR_ST_EXTEND)
				runaway_fire = (ext_q == EXT_LAST[`LVRR_EXT_BITS-1:0]); // RULE5
		end
		// low voltage waits for ram and for running reset
		lv_fire = lv_pend_q && !ram_write_busy && !resetting && !runaway_fire; // RULE8 RULE9
	end

	// next state of the supervisor
	always_comb
	begin
		state_d = state_q;
		ext_d = ext_q;
		pulse_d = pulse_q;
		cnt_d = cnt_q + 1'b1; // RULE2
		case (state_q)
			LVRR_ST_IDLE:
			begin
				ext_d = '0;
				// overflow while recovering from standby: extend
				if (carry && standby_recover && !runaway_clear)
					state_d = LVRR_ST_EXTEND; // RULE5
			end
			LVRR_ST_EXTEND:
			begin
				ext_d = ext_q + 1'b1;
				// a clear during extension aborts it
				if (runaway_clear)
					state_d = LVRR_ST_IDLE;
			end
			LVRR_ST_RUNAWAY_RST:
			begin
				pulse_d = pulse_q + 1'b1;
				// release after the fixed width
				if (pulse_q == RR_CYC[`LVRR_PULSE_BITS-1:0] - 1'b1)
					state_d = LVRR_ST_IDLE; // RULE4
			end
			LVRR_ST_LV_RST:
			begin
				pulse_d = pulse_q + 1'b1;
				if (pulse_q == `LVRR_PULSE_BITS'(`LVRR_LV_RST_CYCLES - 1))
					state_d = LVRR_ST_IDLE;
			end
			default:
				state_d = LVRR_ST_IDLE;
		endcase
		// new reset sources take over
		if (runaway_fire)
		begin
			state_d = LVRR_ST_RUNAWAY_RST; // RULE1
			pulse_d = '0;
		end
		else if (lv_fire)
		begin
			state_d = LVRR_ST_LV_RST; // RULE6
			pulse_d = '0;
		end
		// clear strobe or any internal reset zeroes the counter
		if (runaway_clear || resetting || runaway_fire || lv_fire)
			cnt_d = '0; // RULE10
	end

	// pending request, flag and stop release
	always_comb
	begin
		lv_pend_d = lv_pend_q;
		// detection is live in every mode, stop included
		if (lv_sync && !resetting)
			lv_pend_d = 1'b1; // RULE7
		else if (lv_fire || resetting)
			lv_pend_d = 1'b0; // RULE9
		if (lv_fire)
			lv_pend_d = 1'b0;
		// set wins over clear
		flag_d = flag_q;
		if (flag_clear)
			flag_d = 1'b0;
		if (lv_fire)
			flag_d = 1'b1; // RULE6
		stop_rel_d = (lv_fire || runaway_fire) && stop_mode; // RULE7
		// outputs follow the next state, one flop each
		status_d.internal_reset = (state_d == LVRR_ST_RUNAWAY_RST) || (state_d == LVRR_ST_LV_RST); // RULE4
		status_d.low_voltage_flag = flag_d; // RULE6
		status_d.cause_runaway = (state_d == LVRR_ST_RUNAWAY_RST);
		status_d.cause_low_voltage = (state_d == LVRR_ST_LV_RST);
	end

	// register all state
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state_q <= LVRR_ST_IDLE;
			cnt_q <= '0;
			ext_q <= '0;
			pulse_q <= '0;
			lv_pend_q <= 1'b0;
			flag_q <= 1'b0;
			stop_rel_q <= 1'b0;
			status_q <= '0;
		end
		else
		begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			ext_q <= ext_d;
			pulse_q <= pulse_d;
			lv_pend_q <= lv_pend_d;
			flag_q <= flag_d;
			stop_rel_q <= stop_rel_d;
			status_q <= status_d;
		end
	end

	// outputs straight from state flops
	assign internal_reset = status_q.internal_reset;
	assign stop_release = stop_rel_q;
	assign status = status_q;

	// overflow leads to runaway reset
	runaway_overflow_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE1
		(state_q == LVRR_ST_IDLE && carry && !runaway_clear && !standby_recover)
		|=> state_q == LVRR_ST_RUNAWAY_RST)
		else $error("overflow did not raise runaway reset");

	// counter advances without software
	counter_autorun_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE2
		(state_q == LVRR_ST_IDLE && !carry && !runaway_clear && !lv_fire)
		|=> cnt_q == $past(cnt_q) + 1'b1)
		else $error("runaway counter did not advance");

	// runaway reset width is exact
	runaway_width_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE4
		$rose(status.cause_runaway) |-> status.cause_runaway [*5] ##1 !status.cause_runaway)
		else $error("runaway reset width wrong");

	// extension holds off the reset
	extend_hold_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE5
		(state_q == LVRR_ST_EXTEND && ext_q != EXT_LAST[`LVRR_EXT_BITS-1:0] && !lv_fire)
		|=> !internal_reset)
		else $error("reset during standby extension");

	// low voltage sets flag and reset together
	lv_flag_set_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE6
		lv_fire |=> flag_q && status.cause_low_voltage)
		else $error("low voltage did not set flag and reset");

	// stop mode is released by the reset
	stop_exit_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE7
		(lv_fire && stop_mode) |=> stop_release && internal_reset)
		else $error("stop mode not released");

	// no low-voltage reset starts during ram write
	ram_defer_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE8
		(ram_write_busy && !internal_reset) |=> !status.cause_low_voltage)
		else $error("low-voltage reset during ram write");

	// no new request while reset is out
	lv_suppress_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE9
		internal_reset |=> !$rose(status.low_voltage_flag))
		else $error("low-voltage request not suppressed");

	// clear or reset zeroes the counter
	counter_zero_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE10
		(runaway_clear || internal_reset) |=> cnt_q == '0)
		else $error("runaway counter not zeroed");

	// main scenarios
	cover_runaway_c: cover property (@(posedge clk_sys) disable iff (!reset_n)
		$rose(status.cause_runaway));
	cover_lv_c: cover property (@(posedge clk_sys) disable iff (!reset_n)
		$rose(status.cause_low_voltage));
	cover_extend_c: cover property (@(posedge clk_sys) disable iff (!reset_n)
		state_q == LVRR_ST_EXTEND ##1 runaway_clear);
	cover_ram_wait_c: cover property (@(posedge clk_sys) disable iff (!reset_n)
		(lv_pend_q && ram_write_busy) ##1 lv_fire);

endmodule // lvrr_top

// File: hdl/lvrr_regs.svh
/*
 holds the named constants of the low-voltage and runaway reset supervisor.
 assumes it is included by bare name and that clk_sys runs at 125 mhz.
*/
`ifndef LVRR_REGS_SVH
`define LVRR_REGS_SVH

// clock period of clk_sys in ns
`define LVRR_CLK_PERIOD_NS 8
// width of the runaway counter in bits
`define LVRR_RUNAWAY_BITS 20
// runaway reset width in machine cycles
`define LVRR_RUNAWAY_RST_CYCLES 5
// low-voltage reset width in machine cycles
`define LVRR_LV_RST_CYCLES 5
// extra detection time on standby recovery, in ns
`define LVRR_EXT_TIME_NS 20000
// extra detection time in cycles, rounded up
`define LVRR_EXT_CYCLES ((`LVRR_EXT_TIME_NS + `LVRR_CLK_PERIOD_NS - 1) / `LVRR_CLK_PERIOD_NS)
// width of the extension counter
`define LVRR_EXT_BITS 12
// width of the reset pulse counter
`define LVRR_PULSE_BITS 3
// synchroniser depth for the comparator input
`define LVRR_SYNC_STAGES 2

`endif

// File: hdl/lvrr_pkg.sv
/*
 holds the types shared by the reset supervisor files.
 assumes nothing of its surroundings.
*/
package lvrr_pkg;

	// supervisor states
	typedef enum logic [1:0]
	{
		LVRR_ST_IDLE,
		LVRR_ST_EXTEND,
		LVRR_ST_RUNAWAY_RST,
		LVRR_ST_LV_RST
	} lvrr_state_t;

	// status bundle seen by the cpu and reset distribution
	typedef struct packed
	{
		logic internal_reset;
		logic low_voltage_flag;
		logic cause_runaway;
		logic cause_low_voltage;
	} lvrr_status_t;

endpackage

// File: hdl/lvrr_sync.sv
/*
 holds a multi-bit two-flop synchroniser.
 assumes each bit is an independent level from outside the clk_sys domain.
*/
`timescale 1ns/100ps
`include "lvrr_regs.svh"

module lvrr_sync
	import lvrr_pkg::*;
#(
	parameter int WIDTH = 1
)
(
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	// first stage, read only by the second
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] meta_d;
	// second stage, safe to use
	logic [WIDTH-1:0] sync_q;
	logic [WIDTH-1:0] sync_d;

	// next values of both stages
	always_comb
	begin
		meta_d = async_in;
		sync_d = meta_q;
	end

	// register both stages
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			meta_q <= '0;
			sync_q <= '0;
		end
		else
		begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign sync_out = sync_q;

endmodule // lvrr_sync

// File: verification/lvrr_cpu_model.sv
/*
 holds a behavioural cpu that clears the runaway counter at a fixed period.
 assumes the bench raises kick_en only while the cpu is meant to be running.
*/
`timescale 1ns/100ps

module lvrr_cpu_model
#(
	parameter int PERIOD = 100
)
(
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic internal_reset,
	input wire logic kick_en,
	output logic runaway_clear
);
	// cycles since the last clear
	int unsigned cnt_q;

	// one-cycle clear each period, restarted by any reset
	always @(negedge clk_sys or negedge reset_n)
	begin
		if (!reset_n || internal_reset || !kick_en)
		begin
			cnt_q <= 0;
			runaway_clear <= 1'b0;
		end
		else
		begin
			cnt_q <= (cnt_q == PERIOD - 1) ? 0 : cnt_q + 1;
			runaway_clear <= (cnt_q == PERIOD - 1);
		end
	end
endmodule // lvrr_cpu_model

// File: verification/lvrr_top_test.sv
/*
 holds the self-checking bench of the reset supervisor.
 assumes the design runs with an 8-bit runaway counter.
*/
`timescale 1ns/100ps

module lvrr_top_test;
	import lvrr_pkg::*;
	localparam int BITS = 8;
	logic clk_sys = 0, reset_n = 0, lv = 0, busy = 0, clr, stby = 0, stop = 0, fclr = 0, kick = 0;
	logic irst, srel;
	lvrr_status_t status;
	int errors = 0, comparisons = 0, n, w;

	lvrr_top #(.RUNAWAY_BITS(BITS)) dut (.clk_sys(clk_sys), .reset_n(reset_n), .low_voltage_async(lv),
		.ram_write_busy(busy), .runaway_clear(clr), .standby_recover(stby), .stop_mode(stop),
		.flag_clear(fclr), .internal_reset(irst), .stop_release(srel), .status(status));
	lvrr_cpu_model #(.PERIOD(100)) cpu (.clk_sys(clk_sys), .reset_n(reset_n), .internal_reset(irst),
		.kick_en(kick), .runaway_clear(clr));

	// 8 ns clock
	initial
	begin
		forever #4 clk_sys = ~clk_sys;
	end

	// compare and count
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			errors++;
			$display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
		end
	endtask

	task automatic complete_run;
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// power-on reset, released on a falling edge
	task automatic do_reset;
		@(negedge clk_sys);
		reset_n = 0;
		repeat (20) @(negedge clk_sys);
		reset_n = 1;
	endtask

	// falling edges until reset shows, then its width
	task automatic wait_rst(input int lim);
		n = 0;
		while (irst !== 1'b1 && n < lim)
		begin
			@(negedge clk_sys);
			n++;
		end
	endtask

	task automatic width;
		w = 0;
		while (irst === 1'b1 && w < 50)
		begin
			w++;
			@(negedge clk_sys);
		end
	endtask

	// overflow without clear, twice
	task automatic t_autostart;
		do_reset();
		wait_rst(400);
		check("first overflow", n, 1 << BITS);
		check("runaway status", status, 4'ha);
		check("no stop release", srel, 0);
		width();
		check("runaway width", w, 5);
		wait_rst(400);
		check("restart after reset", n, 1 << BITS);
	endtask

	// periodic clears keep reset away
	task automatic t_kick;
		do_reset();
		kick = 1;
		w = 0;
		repeat (1000)
		begin
			@(negedge clk_sys);
			w += (irst === 1'b1);
		end
		check("kicked resets", w, 0);
		kick = 0;
	endtask

	// low voltage in stop mode, held through the reset
	task automatic t_lv_stop;
		do_reset();
		stop = 1;
		lv = 1;
		wait_rst(20);
		check("lv latency", n, 4);
		check("lv status", status, 4'hd);
		check("stop release", srel, 1);
		width();
		check("lv width", w, 5);
		lv = 0;
		stop = 0;
		repeat (20) @(negedge clk_sys);
		check("flag sticky", status.low_voltage_flag, 1);
		fclr = 1;
		@(negedge clk_sys);
		fclr = 0;
		@(negedge clk_sys);
		check("flag cleared", status.low_voltage_flag, 0);
	endtask

	// ram write holds back the low-voltage reset
	task automatic t_ram;
		do_reset();
		busy = 1;
		lv = 1;
		repeat (20) @(negedge clk_sys);
		check("reset during write", irst, 0);
		busy = 0;
		wait_rst(10);
		check("reset after write", n, 1);
		lv = 0;
		repeat (20) @(negedge clk_sys);
	endtask

	// standby recovery stretches the period by 2500 cycles
	task automatic t_standby;
		do_reset();
		stby = 1;
		wait_rst(4000);
		check("extended overflow", n, (1 << BITS) + 2500);
		stby = 0;
	endtask

	// a clear during the standby extension cancels the pending reset
	task automatic t_standby_clear;
		do_reset();
		stby = 1;
		repeat (300) @(negedge clk_sys);
		check("in extension", irst, 0);
		kick = 1;
		w = 0;
		repeat (3000)
		begin
			@(negedge clk_sys);
			w += (irst === 1'b1);
		end
		check("cleared extension", w, 0);
		kick = 0;
		stby = 0;
	endtask

	initial
	begin
		t_autostart();
		t_kick();
		t_lv_stop();
		t_ram();
		t_standby_clear();
		t_standby();
		complete_run();
	end

	// hang guard
	initial
	begin
		repeat (20000) @(posedge clk_sys);
		errors++;
		complete_run();
	end
endmodule // lvrr_top_test
